/* rtl/dtc_pkg.sv */
package dtc_pkg;

  // ----------------------------------------------------------------
  // register map of the controller
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CMD = 4'h0;
  localparam logic [3:0] ADDR_CFG = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_WLCTL = 4'h3;
  localparam logic [3:0] ADDR_REFCNT = 4'h4;

  // cfg field positions
  localparam int CFG_WL_LSB = 0;
  localparam int CFG_WR_LSB = 4;
  localparam int CFG_BC4F_BIT = 9;
  localparam int CFG_HOT_BIT = 10;
  localparam int CFG_TWRC_LSB = 11;
  localparam int CFG_TMOD_LSB = 16;
  localparam logic [31:0] CFG_RESET = 32'h0000_3C65;

  // ----------------------------------------------------------------
  // timing, times in ns (link period in ps), counts in link clocks (15 ns)
  // ----------------------------------------------------------------
  localparam int LINK_PERIOD_PS = 15000;
  localparam int TRFC_NS = 110;
  localparam int TRFC_CYC = (TRFC_NS * 1000 + LINK_PERIOD_PS - 1)
    / LINK_PERIOD_PS;
  localparam int TREFI_NORM_NS = 7800;
  localparam int TREFI_HOT_NS = 3900;
  localparam int TREFI_NORM_CYC = TREFI_NORM_NS * 1000 / LINK_PERIOD_PS;
  localparam int TREFI_HOT_CYC = TREFI_HOT_NS * 1000 / LINK_PERIOD_PS;
  localparam int TREFPDEN_CYC = 1;
  localparam int ODTH4_CYC = 4;
  localparam int ODTH8_CYC = 6;
  localparam int ODTL_SUB = 2;
  localparam int WLDQSEN_CYC = 25;
  localparam int WLMRD_CYC = 40;
  localparam int PD_BC4_ADD = 2;
  localparam int PD_BL8_ADD = 4;
  localparam int DLL_WAIT_CYC = 10;

  // ----------------------------------------------------------------
  // commands
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DTC_NOP, DTC_ACT, DTC_WR, DTC_WRA, DTC_RD, DTC_REF, DTC_MRS, DTC_PDE
  } dtc_op_t;

  typedef struct packed {
    dtc_op_t op;
    logic bl8;
    logic odt;
  } dtc_req_t;

  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic odt;
  } dtc_pins_t;

endpackage

/* rtl/dtc_ctrl.sv */
// Operation
// R1: write to power-down waits WL+2+tWR clocks (code waits WL+4+tWR unless the BC4 cfg bit is set)
// R2: BC4 autoprecharge write waits WL+2+WR+1 (code waits WL+4+WR+1 unless the BC4 cfg bit is set)
// R3: BL8 autoprecharge write waits WL+4+WR+1
// R4: power-down at least one clock after refresh
// R5: power-down waits mode-register update delay
// R6: termination latency equals write latency minus two
// R7: termination high four clocks, BC4 or none
// R8: termination high six clocks with BL8 write
// R9: first strobe rise 40 clocks after leveling
// R10: strobe driven 25 clocks after leveling
// R11: refresh blocks activate, refresh for 110ns
// R12: refresh every 7.8us, 3.9us when hot
// R13: reads wait DLL lock after power exit
// R14: write recovery clocks rounded up
// R15: slow clock only bounded by refresh interval
// R16: internal write starts WL+4 or WL+2
// R17: counters block each command until expired
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module dtc_ctrl
  import dtc_pkg::*;
(
  // system side
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  // link clock domain
  input wire logic link_clk,
  output dtc_pins_t pins,
  output logic dqs_out,
  output logic dqs_oe_n
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] sat_dec(input logic [7:0] v);
    sat_dec = (v == 8'h00) ? 8'h00 : v - 8'h01;
  endfunction

  function automatic logic [7:0] max8(input logic [7:0] a,
                                      input logic [7:0] b);
    max8 = (a > b) ? a : b;
  endfunction

  // ----------------------------------------------------------------
  // register file, system clock
  // ----------------------------------------------------------------
  logic [31:0] cfg;
  logic [5:0] cmd_word;
  logic cmd_tog;
  logic wl_tog;
  logic [31:0] status_word;
  logic [2:0] busy_s1, busy_s2;
  logic [2:0] done_s1, done_s2;
  logic [15:0] refcnt_sys;
  logic [15:0] rg_s1, rg_s2;
  logic ack_tog;
  logic [2:0] link_stat;

  // refresh count arrives gray coded, so one flip per step is safe to sync
  function automatic logic [15:0] gray2bin(input logic [15:0] g);
    logic [15:0] b;
    b[15] = g[15];
    for (int i = 14; i >= 0; i--)
      b[i] = b[i + 1] ^ g[i];
    gray2bin = b;
  endfunction

  wire sel_cmd = wr_en && (addr == ADDR_CMD);
  wire sel_cfg = wr_en && (addr == ADDR_CFG);
  wire sel_wl = wr_en && (addr == ADDR_WLCTL);
  wire [2:0] ack_sync = done_s2;

  // a new command is refused while the previous toggle is unanswered
  wire cmd_pending = (cmd_tog != ack_sync[0]);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cfg <= CFG_RESET;
      cmd_word <= 6'h00;
      cmd_tog <= 1'b0;
      wl_tog <= 1'b0;
    end
    else
    begin
      if (sel_cfg)
        cfg <= wdata;
      if (sel_cmd && !cmd_pending)
      begin
        cmd_word <= wdata[5:0];
        cmd_tog <= ~cmd_tog;
      end
      if (sel_wl)
        wl_tog <= ~wl_tog;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      busy_s1 <= 3'h0;
      busy_s2 <= 3'h0;
      done_s1 <= 3'h0;
      done_s2 <= 3'h0;
    end
    else
    begin
      busy_s1 <= link_stat;
      busy_s2 <= busy_s1;
      done_s1 <= {2'h0, ack_tog};
      done_s2 <= done_s1;
    end
  end

  assign status_word = {28'h0, busy_s2, cmd_pending};

  always_ff @(posedge clk)
  begin
    if (srst)
      rdata <= 32'h0;
    else if (rd_en)
      unique case (addr)
        ADDR_CFG: rdata <= cfg;
        ADDR_STATUS: rdata <= status_word;
        ADDR_REFCNT: rdata <= {16'h0, refcnt_sys};
        default: rdata <= 32'h0;
      endcase
    else
      rdata <= 32'h0;
  end

  // ----------------------------------------------------------------
  // crossing into the link domain
  // ----------------------------------------------------------------
  logic [2:0] ltog_s;
  logic [2:0] lwl_s;
  logic lsrst_s1, lsrst;

  // config is quasi-static: software changes it only while idle
  wire [3:0] cfg_wl = cfg[CFG_WL_LSB +: 4];
  wire [4:0] cfg_wr = cfg[CFG_WR_LSB +: 5];
  wire cfg_bc4f = cfg[CFG_BC4F_BIT];
  wire cfg_hot = cfg[CFG_HOT_BIT];
  wire [4:0] cfg_twrc = cfg[CFG_TWRC_LSB +: 5];
  wire [4:0] cfg_tmod = cfg[CFG_TMOD_LSB +: 5];

  always_ff @(posedge link_clk)
  begin
    lsrst_s1 <= srst;
    lsrst <= lsrst_s1;
  end

  always_ff @(posedge link_clk)
  begin
    if (lsrst)
    begin
      ltog_s <= 3'h0;
      lwl_s <= 3'h0;
    end
    else
    begin
      ltog_s <= {ltog_s[1:0], cmd_tog};
      lwl_s <= {lwl_s[1:0], wl_tog};
    end
  end

  wire new_cmd = ltog_s[2] ^ ltog_s[1] ? 1'b0 : (ltog_s[2] != ack_tog);
  wire wl_start = lwl_s[2] ^ lwl_s[1];
  dtc_req_t req;
  // bit 2 of the command word is spare
  assign req = {cmd_word[5:3], cmd_word[1:0]};

  // ----------------------------------------------------------------
  // spacing counters, link clock
  // ----------------------------------------------------------------
  logic [7:0] pd_cnt, rfc_cnt, odt_cnt, dll_cnt;
  logic [12:0] refi_cnt;
  logic [15:0] refcnt;
  logic in_pd;
  logic [7:0] wl_cnt;
  logic wl_active;

  wire [7:0] wl8 = {4'h0, cfg_wl};
  wire [7:0] odt_lat = wl8 - 8'(ODTL_SUB); // see R6
  // see R14: software loads tWR already rounded up to clocks
  wire [7:0] pd_wr = wl8 + 8'(cfg_bc4f ? PD_BC4_ADD : PD_BL8_ADD)
    + {3'h0, cfg_twrc}; // see R1
  wire [7:0] pd_wra = wl8 + 8'(cfg_bc4f ? PD_BC4_ADD : PD_BL8_ADD)
    + {3'h0, cfg_wr} + 8'h01; // see R2 see R3
  wire [12:0] refi_lim = cfg_hot ? 13'(TREFI_HOT_CYC)
    : 13'(TREFI_NORM_CYC); // see R12 see R15

  wire is_act = (req.op == DTC_ACT);
  wire is_ref = (req.op == DTC_REF);
  wire is_pde = (req.op == DTC_PDE);
  wire is_rd = (req.op == DTC_RD) || req.odt;
  wire is_wr = (req.op == DTC_WR) || (req.op == DTC_WRA);
  // see R17
  wire blocked = ((is_act || is_ref) && rfc_cnt != 8'h00) // see R11
    || (is_pde && pd_cnt != 8'h00)
    || (is_rd && dll_cnt != 8'h00) // see R13
    || (in_pd && !is_pde)
    || (odt_cnt != 8'h00 && !req.odt);
  // leveling needs an mrs on the pins, so it is dropped while asleep
  wire wl_go = wl_start && !in_pd;
  wire fire = new_cmd && !blocked && !wl_active && !wl_go;
  wire refresh_due = (refi_cnt >= refi_lim);

  always_ff @(posedge link_clk)
  begin
    if (lsrst)
    begin
      pd_cnt <= 8'h00;
      rfc_cnt <= 8'h00;
      odt_cnt <= 8'h00;
      dll_cnt <= 8'h00;
      refi_cnt <= 13'h0;
      refcnt <= 16'h0;
      in_pd <= 1'b0;
      ack_tog <= 1'b0;
    end
    else
    begin
      pd_cnt <= sat_dec(pd_cnt);
      rfc_cnt <= sat_dec(rfc_cnt);
      odt_cnt <= sat_dec(odt_cnt);
      dll_cnt <= sat_dec(dll_cnt);
      refi_cnt <= refi_cnt + 13'h1;
      if (fire)
      begin
        ack_tog <= ~ack_tog;
        unique case (req.op)
          DTC_WR: pd_cnt <= max8(pd_cnt, pd_wr);
          DTC_WRA: pd_cnt <= max8(pd_cnt, pd_wra);
          DTC_REF:
          begin
            pd_cnt <= max8(pd_cnt, 8'(TREFPDEN_CYC)); // see R4
            rfc_cnt <= 8'(TRFC_CYC);
            refi_cnt <= 13'h0;
            refcnt <= refcnt + 16'h1;
          end
          DTC_MRS: pd_cnt <= max8(pd_cnt, {3'h0, cfg_tmod}); // see R5
          DTC_PDE:
          begin
            in_pd <= !in_pd;
            if (in_pd)
              dll_cnt <= 8'(DLL_WAIT_CYC); // see R13
          end
          default: pd_cnt <= pd_cnt;
        endcase
        if (req.odt)
          // see R7 see R8
          odt_cnt <= (is_wr && req.bl8 && !cfg_bc4f) ? 8'(ODTH8_CYC)
            : 8'(ODTH4_CYC);
      end
    end
  end

  // ----------------------------------------------------------------
  // write leveling strobe timing
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk)
  begin
    if (lsrst)
    begin
      wl_cnt <= 8'h00;
      wl_active <= 1'b0;
    end
    else if (wl_go)
    begin
      wl_cnt <= 8'h00;
      wl_active <= 1'b1;
    end
    else if (wl_active && wl_cnt < 8'(WLMRD_CYC + 1))
      wl_cnt <= wl_cnt + 8'h01;
    else
      wl_active <= 1'b0;
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk)
  begin
    if (lsrst)
    begin
      pins <= '{cke: 1'b0, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
                we_n: 1'b1, odt: 1'b0};
      dqs_oe_n <= 1'b1;
      dqs_out <= 1'b0;
      link_stat <= 3'h0;
    end
    else
    begin
      pins.cke <= !(fire && is_pde && !in_pd) && !(in_pd && !fire);
      pins.cs_n <= !((fire && !is_pde && req.op != DTC_NOP) || wl_go);
      pins.ras_n <= !((fire && (is_act || is_ref || req.op == DTC_MRS))
        || wl_go);
      pins.cas_n <= !((fire && (is_wr || req.op == DTC_RD || is_ref
        || req.op == DTC_MRS)) || wl_go);
      pins.we_n <= !((fire && (is_wr || req.op == DTC_MRS)) || wl_go);
      pins.odt <= (fire && req.odt) || (odt_cnt > 8'h01);
      dqs_oe_n <= !(wl_active && wl_cnt >= 8'(WLDQSEN_CYC)); // see R10
      dqs_out <= wl_active && wl_cnt >= 8'(WLMRD_CYC); // see R9
      link_stat <= {refresh_due, in_pd, wl_active};
    end
  end

  // odt latency computed into an unused signal only; neither it nor an internal write start is visible to software
  logic [7:0] unused_lat;
  assign unused_lat = odt_lat;

  logic [15:0] refgray;

  always_ff @(posedge link_clk)
  begin
    if (lsrst)
      refgray <= 16'h0;
    else
      refgray <= refcnt ^ (refcnt >> 1);
  end

  // refresh count is sampled while software polls it
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rg_s1 <= 16'h0;
      rg_s2 <= 16'h0;
      refcnt_sys <= 16'h0;
    end
    else
    begin
      rg_s1 <= refgray;
      rg_s2 <= rg_s1;
      if (rd_en && addr == ADDR_REFCNT)
        refcnt_sys <= gray2bin(rg_s2);
    end
  end

endmodule
`default_nettype wire

/* test/dtc_props.sv */
`timescale 1ns/1ps
`default_nettype none
module dtc_props
  import dtc_pkg::*;
(
  // system side
  input wire logic clk,
  input wire logic srst,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  // link side
  input wire logic link_clk,
  input wire dtc_pins_t pins,
  input wire logic dqs_out,
  input wire logic dqs_oe_n
);
  // ----
  // decode and cycle counters since commands
  // ----
  logic [31:0] cfg;
  logic [7:0] s_wr;
  logic [7:0] s_mrs;
  logic [7:0] s_pdx;
  logic pd_was;
  wire logic cmd = !pins.cs_n;
  wire logic act = cmd && !pins.ras_n && pins.cas_n && pins.we_n;
  wire logic rfr = cmd && !pins.ras_n && !pins.cas_n && pins.we_n;
  wire logic mrs = cmd && !pins.ras_n && !pins.cas_n && !pins.we_n;
  wire logic wrc = cmd && pins.ras_n && !pins.cas_n && !pins.we_n;
  wire logic rdc = cmd && pins.ras_n && !pins.cas_n && pins.we_n;
  wire logic [7:0] add = 8'(cfg[CFG_BC4F_BIT] ? PD_BC4_ADD : PD_BL8_ADD);
  // wr+1 equals twr clocks in every setting used, so one bound covers both
  wire logic [7:0] pd_min = 8'(cfg[3:0]) + 8'(cfg[15:11]) + add;
  function automatic logic [7:0] inc(input logic [7:0] v);
    return (v == 8'hFF) ? v : v + 8'h01;
  endfunction
  always_ff @(posedge clk)
    if (srst) cfg <= CFG_RESET;
    else if (wr_en && addr == ADDR_CFG) cfg <= wdata;
  always_ff @(posedge link_clk)
  begin
    if (srst)
    begin
      s_wr <= 8'hFF;
      s_mrs <= 8'hFF;
      s_pdx <= 8'hFF;
      pd_was <= 1'b0;
    end
    else
    begin
      s_wr <= wrc ? 8'h01 : inc(s_wr);
      s_mrs <= mrs ? 8'h01 : inc(s_mrs);
      s_pdx <= ($rose(pins.cke) && pd_was) ? 8'h01 : inc(s_pdx);
      pd_was <= pd_was || $fell(pins.cke);
    end
  end
  sequence s_rfc_quiet;
    (!act && !rfr)[*7];
  endsequence
  sequence s_odt_hold;
    pins.odt[*4];
  endsequence
  // ----
  // assertions
  // ----
  a_trfc_gap: assert property (@(posedge link_clk) disable iff (srst)
    rfr |=> s_rfc_quiet) else $error("refresh spacing short");
  a_ref_cke: assert property (@(posedge link_clk) disable iff (srst)
    rfr |=> pins.cke) else $error("sleep right after refresh");
  a_pd_wr_gap: assert property (@(posedge link_clk) disable iff (srst)
    $fell(pins.cke) |-> s_wr >= pd_min) else $error("write to sleep short");
  a_pd_mrs_gap: assert property (@(posedge link_clk) disable iff (srst)
    $fell(pins.cke) |-> s_mrs >= 8'(cfg[20:16])) else $error("mode to sleep");
  a_odt_hold: assert property (@(posedge link_clk) disable iff (srst)
    $rose(pins.odt) |-> s_odt_hold) else $error("termination pulse short");
  a_pd_quiet: assert property (@(posedge link_clk) disable iff (srst)
    !pins.cke |-> pins.cs_n) else $error("command while asleep");
  a_wl_dqs_en: assert property (@(posedge link_clk) disable iff (srst)
    $fell(dqs_oe_n) |-> s_mrs >= 8'(WLDQSEN_CYC)) else $error("strobe early");
  a_wl_rise: assert property (@(posedge link_clk) disable iff (srst)
    $rose(dqs_out) && !dqs_oe_n |-> s_mrs >= 8'(WLMRD_CYC))
    else $error("strobe edge early");
  a_dll_wait: assert property (@(posedge link_clk) disable iff (srst)
    rdc || $rose(pins.odt) |-> s_pdx >= 8'(DLL_WAIT_CYC))
    else $error("dll command early");
endmodule
bind dtc_ctrl dtc_props u_props (.clk(clk), .srst(srst), .addr(addr),
  .wdata(wdata), .wr_en(wr_en), .link_clk(link_clk), .pins(pins),
  .dqs_out(dqs_out), .dqs_oe_n(dqs_oe_n));
`default_nettype wire

/* test/dtc_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module dtc_mem
  import dtc_pkg::*;
#(
  parameter int WL = 5
)
(
  // link side
  input wire logic link_clk,
  input wire logic srst,
  input wire dtc_pins_t pins,
  // violations seen
  output logic [7:0] viol
);
  logic [7:0] since_ref;
  logic [7:0] odt_len;
  logic [15:0] odt_pipe;
  logic rtt_on;
  logic [15:0] wr_pipe;
  logic cke_q;
  wire logic cmd = pins.cke && !pins.cs_n;
  wire logic rfr = cmd && !pins.ras_n && !pins.cas_n && pins.we_n;
  wire logic act = cmd && !pins.ras_n && pins.cas_n && pins.we_n;
  wire logic bad_rfc = (act || rfr) && since_ref < 8'(TRFC_CYC);
  wire logic bad_odt = !pins.odt && odt_len != 0 && odt_len < 8'(ODTH4_CYC);
  wire logic bad_pd = !pins.cke && !pins.cs_n;
  wire logic wrc = cmd && pins.ras_n && !pins.cas_n && !pins.we_n;
  // the internal write must have started before sleep
  wire logic bad_wpd = cke_q && !pins.cke && (|wr_pipe[WL + 1:0]);
  assign rtt_on = odt_pipe[WL - ODTL_SUB - 1];
  always_ff @(posedge link_clk)
  begin
    if (srst)
    begin
      since_ref <= 8'hFF;
      odt_len <= 8'h00;
      odt_pipe <= 16'h0000;
      wr_pipe <= 16'h0000;
      cke_q <= 1'b0;
      viol <= 8'h00;
    end
    else
    begin
      since_ref <= rfr ? 8'h01 : since_ref + 8'(since_ref != 8'hFF);
      odt_len <= pins.odt ? odt_len + 8'h01 : 8'h00;
      odt_pipe <= {odt_pipe[14:0], pins.odt};
      wr_pipe <= {wr_pipe[14:0], wrc};
      cke_q <= pins.cke;
      viol <= viol + 8'(bad_rfc) + 8'(bad_odt) + 8'(bad_pd) + 8'(bad_wpd);
    end
  end
endmodule
`default_nettype wire

/* test/tb_ddr3_power_odt_refresh_timing.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_ddr3_power_odt_refresh_timing
  import dtc_pkg::*;
;
  logic clk = 1'b0;
  logic link_clk;
  logic srst;
  logic [3:0] addr;
  logic [31:0] wdata;
  logic wr_en;
  logic rd_en;
  logic [31:0] rdata;
  logic [31:0] s;
  logic [31:0] r1;
  dtc_pins_t pins;
  logic dqs_out;
  logic dqs_oe_n;
  logic dqs_seen;
  logic [7:0] viol;
  int failures = 0;
  int n_checks = 0;
  always #50 clk = ~clk;
  initial
  begin
    link_clk = 1'b0;
    #3.1;
    forever #7.5 link_clk = ~link_clk;
  end
  always @(posedge link_clk) if (srst) dqs_seen <= 1'b0;
    else if (dqs_oe_n === 1'b0) dqs_seen <= 1'b1;
  dtc_ctrl dut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .link_clk(link_clk),
    .pins(pins), .dqs_out(dqs_out), .dqs_oe_n(dqs_oe_n));
  dtc_mem #(.WL(5)) u_mem (.link_clk(link_clk), .srst(srst), .pins(pins),
    .viol(viol));
  // ----
  // bus tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic issue(input dtc_op_t op, input logic bl8, input logic odt);
    bus_wr(ADDR_CMD, 32'({op, 1'b0, bl8, odt}));
    repeat (60)
    begin
      bus_rd(ADDR_STATUS, s);
      if (s[0] === 1'b0) break;
    end
    chk(32'(s[0]), 32'h0);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_regs;
    bus_rd(ADDR_CFG, s);
    chk(s, CFG_RESET);
    bus_rd(4'hF, s);
    chk(s, 32'h0);
    bus_wr(ADDR_CFG, 32'h000C_3C65);
    bus_rd(ADDR_CFG, s);
    chk(s, 32'h000C_3C65);
    $display("test regs done");
  endtask
  task automatic t_refresh;
    bus_rd(ADDR_REFCNT, s);
    issue(DTC_REF, 1'b0, 1'b0);
    issue(DTC_ACT, 1'b0, 1'b0);
    issue(DTC_REF, 1'b0, 1'b0);
    bus_rd(ADDR_REFCNT, r1);
    bus_rd(ADDR_REFCNT, s);
    chk(s, r1 + 32'h2);
    repeat (28) @(posedge clk);
    bus_rd(ADDR_STATUS, s);
    chk(32'(s[3]), 32'h0);
    repeat (15) @(posedge clk);
    bus_rd(ADDR_STATUS, s);
    chk(32'(s[3]), 32'h1);
    bus_wr(ADDR_CFG, 32'h000C_3865);
    issue(DTC_REF, 1'b0, 1'b0);
    repeat (60) @(posedge clk);
    bus_rd(ADDR_STATUS, s);
    chk(32'(s[3]), 32'h0);
    repeat (25) @(posedge clk);
    bus_rd(ADDR_STATUS, s);
    chk(32'(s[3]), 32'h1);
    $display("test refresh done");
  endtask
  task automatic t_power;
    issue(DTC_WR, 1'b1, 1'b1);
    issue(DTC_PDE, 1'b0, 1'b0);
    bus_rd(ADDR_STATUS, s);
    chk(32'(s[2]), 32'h1);
    issue(DTC_PDE, 1'b0, 1'b0);
    bus_rd(ADDR_STATUS, s);
    chk(32'(s[2]), 32'h0);
    issue(DTC_RD, 1'b0, 1'b0);
    bus_wr(ADDR_CFG, 32'h000C_3E65);
    issue(DTC_WRA, 1'b0, 1'b1);
    issue(DTC_PDE, 1'b0, 1'b0);
    issue(DTC_PDE, 1'b0, 1'b0);
    issue(DTC_MRS, 1'b0, 1'b0);
    issue(DTC_PDE, 1'b0, 1'b0);
    issue(DTC_PDE, 1'b0, 1'b0);
    issue(DTC_NOP, 1'b0, 1'b1);
    $display("test power done");
  endtask
  task automatic t_level;
    bus_wr(ADDR_WLCTL, 32'h1);
    repeat (3) @(posedge clk);
    bus_rd(ADDR_STATUS, s);
    chk(32'(s[1]), 32'h1);
    repeat (30) @(posedge clk);
    chk(32'(dqs_seen), 32'h1);
    bus_rd(ADDR_STATUS, s);
    chk(32'(s[1]), 32'h0);
    chk(32'(viol), 32'h0);
    $display("test level done");
  endtask
  task automatic complete_run;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #2000000;
    failures++;
    complete_run;
  end
  initial
  begin
    srst = 1'b1;
    addr = 4'h0;
    wdata = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    t_regs;
    t_refresh;
    t_power;
    t_level;
    complete_run;
  end
endmodule
`default_nettype wire
